// ---- rtl/twd_map.svh ----
// Register selects, field positions, reset values and command codes of the debug port
`ifndef TWD_MAP_SVH
`define TWD_MAP_SVH

`define TWD_SEL_PART_ID     8'h00
`define TWD_SEL_REVISION    8'h01
`define TWD_SEL_FLASH_CTL   8'h02
`define TWD_SEL_FLASH_DATA  8'hB4

`define TWD_CTL_HALT_BIT    0
`define TWD_CTL_FLASH_BIT   1

`define TWD_SEL_RESET       8'h00
`define TWD_CTL_RESET       8'h00
`define TWD_FDATA_RESET     8'h00

`define TWD_CMD_BLOCK_READ  8'h06
`define TWD_CMD_BLOCK_WRITE 8'h07

`define TWD_WORD_BITS       3'h7

`endif

// ---- rtl/twd_pkg.sv ----
// Types shared by the two-wire debug port modules
package twd_pkg;

    typedef enum logic [1:0] {
        TWD_INS_WR_SEL,
        TWD_INS_RD_SEL,
        TWD_INS_WR_DATA,
        TWD_INS_RD_DATA
    } twd_ins_t;

    typedef enum logic [2:0] {
        TWD_L_IDLE,
        TWD_L_INS,
        TWD_L_DATA,
        TWD_L_WAIT,
        TWD_L_ACK,
        TWD_L_SEND
    } twd_lstate_t;

endpackage : twd_pkg

// ---- rtl/twd_link.sv ----
// Link-clock side of the debug port: frame shifter and handshake to the core clock
`timescale 1ns/1ps
`include "twd_map.svh"

module twd_link (
    input  wire logic       link_clk,
    input  wire logic       srst,
    input  wire logic       link_din,
    output logic            link_dout,
    output logic            link_doe,
    output logic            req_tgl,
    output logic [1:0]      req_ins,
    output logic [7:0]      req_data,
    input  wire logic       ack_tgl,
    input  wire logic [7:0] ack_data
);

    twd_pkg::twd_lstate_t state;
    twd_pkg::twd_lstate_t next_state;
    logic [2:0]           cnt;
    logic [2:0]           next_cnt;
    logic [7:0]           shreg;
    logic [7:0]           next_shreg;
    logic [1:0]           next_req_ins;
    logic [7:0]           next_req_data;
    logic                 next_req_tgl;
    logic                 next_dout;
    logic                 next_doe;
    logic                 rst_s1;
    logic                 rst_s2;
    logic                 ack_s1;
    logic                 ack_s2;
    logic                 ack_prev;
    logic                 ack_new;
    logic                 is_read;

    // Core reset reaches this domain only while the host clocks the link
    always_ff @(posedge link_clk)
    begin
        rst_s1 <= srst;
        rst_s2 <= rst_s1;
        ack_s1 <= ack_tgl;
        ack_s2 <= ack_s1;
    end

    assign ack_new = ack_s2 != ack_prev;
    assign is_read = req_ins[0];

    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt;
        next_shreg    = shreg;
        next_req_ins  = req_ins;
        next_req_data = req_data;
        next_req_tgl  = req_tgl;
        next_dout     = link_dout;
        next_doe      = link_doe;
        case (state)
            twd_pkg::TWD_L_IDLE:
            begin
                next_doe = 1'b0;
                next_cnt = 3'h0;
                if (link_din)
                    next_state = twd_pkg::TWD_L_INS;
            end
            twd_pkg::TWD_L_INS:
            begin
                // Instruction arrives LSB first, two bits
                next_req_ins = {link_din, req_ins[1]};
                next_cnt     = cnt + 3'h1;
                if (cnt == 3'h1)
                begin
                    next_cnt = 3'h0;
                    // Read bit came first and now sits in the upper slot
                    if (req_ins[1])
                    begin
                        next_state   = twd_pkg::TWD_L_WAIT;
                        next_req_tgl = ~req_tgl;
                        next_doe     = 1'b1;
                        next_dout    = 1'b0;
                    end
                    else
                        next_state = twd_pkg::TWD_L_DATA;
                end
            end
            twd_pkg::TWD_L_DATA:
            begin
                next_shreg = {link_din, shreg[7:1]};
                next_cnt   = cnt + 3'h1;
                if (cnt == `TWD_WORD_BITS)
                begin
                    next_req_data = {link_din, shreg[7:1]};
                    next_req_tgl  = ~req_tgl;
                    next_state    = twd_pkg::TWD_L_WAIT;
                    next_doe      = 1'b1;
                    next_dout     = 1'b0;
                end
            end
            twd_pkg::TWD_L_WAIT:
            begin
                // Busy bit low until the core has absorbed the frame
                if (ack_new)
                begin
                    next_dout  = 1'b1;
                    next_shreg = ack_data;
                    next_state = twd_pkg::TWD_L_ACK;
                end
            end
            twd_pkg::TWD_L_ACK:
            begin
                if (is_read)
                begin
                    next_dout  = shreg[0];
                    next_cnt   = 3'h1;
                    next_state = twd_pkg::TWD_L_SEND;
                end
                else
                begin
                    next_doe   = 1'b0;
                    next_state = twd_pkg::TWD_L_IDLE;
                end
            end
            twd_pkg::TWD_L_SEND:
            begin
                next_dout = shreg[cnt];
                next_cnt  = cnt + 3'h1;
                if (cnt == 3'h0)
                begin
                    next_doe   = 1'b0;
                    next_state = twd_pkg::TWD_L_IDLE;
                end
            end
            default:
                next_state = twd_pkg::TWD_L_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (rst_s2)
        begin
            state     <= twd_pkg::TWD_L_IDLE;
            cnt       <= 3'h0;
            shreg     <= 8'h00;
            req_ins   <= 2'h0;
            req_data  <= 8'h00;
            req_tgl   <= 1'b0;
            link_dout <= 1'b0;
            link_doe  <= 1'b0;
            ack_prev  <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            shreg     <= next_shreg;
            req_ins   <= next_req_ins;
            req_data  <= next_req_data;
            req_tgl   <= next_req_tgl;
            link_dout <= next_dout;
            link_doe  <= next_doe;
            if (state == twd_pkg::TWD_L_WAIT)
                ack_prev <= ack_s2;
        end
    end

    a_link_wait_drive: assert property (
        @(posedge link_clk) disable iff (rst_s2)
        (state == twd_pkg::TWD_L_WAIT) |-> (link_doe && !link_dout))
        else $error("Busy bit not driven low while waiting");

    a_link_read_len: assert property (
        @(posedge link_clk) disable iff (rst_s2)
        (state == twd_pkg::TWD_L_ACK && is_read) |=> link_doe [*8] ##1 !link_doe)
        else $error("Read data not driven for exactly eight bits");

endmodule : twd_link

// ---- rtl/twd_port.sv ----
// Two-wire debug port: register file, pin sharing and flash byte path
// Notes on behaviour
// - Host clock plus one two-way data wire.
// - Debug registers reachable only over the link.
// - Halt stalls peripherals and user program.
// - Clock on reset pin, data on port pin.
`timescale 1ns/1ps
`include "twd_map.svh"

module twd_port #(
    parameter logic [7:0] PART_ID  = 8'h5A, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01  // Arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       debug_link_clock,
    input  wire logic       shared_port_pin_in,
    output logic            shared_port_pin_out,
    output logic            shared_port_pin_oe,
    input  wire logic       user_pin_out,
    input  wire logic       user_pin_oe,
    output logic            user_pin_in,
    output logic            core_stall,
    output logic [7:0]      flash_byte,
    output logic            flash_byte_strobe,
    output logic            flash_blk_rd_cmd,
    output logic            flash_blk_wr_cmd,
    input  wire logic       flash_rd_valid,
    input  wire logic [7:0] flash_rd_byte,
    input  wire logic       flash_cmd_done
);

    logic       link_dout;
    logic       link_doe;
    logic       req_tgl;
    logic [1:0] req_ins;
    logic [7:0] req_data;
    logic       req_s1;
    logic       req_s2;
    logic       req_prev;
    logic       req_new;
    logic       pin_s1;
    logic       pin_s2;
    logic       ack_tgl;
    logic       next_ack_tgl;
    logic [7:0] ack_data;
    logic [7:0] next_ack_data;
    logic [7:0] sel;
    logic [7:0] next_sel;
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    logic [7:0] flash_prog_data_reg;
    logic [7:0] next_fdata;
    logic       cmd_phase;
    logic       next_cmd_phase;
    logic [7:0] next_flash_byte;
    logic       next_strobe;
    logic       next_blk_rd;
    logic       next_blk_wr;
    logic       data_wr;

    function automatic logic [7:0] read_mux(input logic [7:0] s, input logic [7:0] c,
                                            input logic [7:0] f);
        case (s)
            `TWD_SEL_PART_ID:    read_mux = PART_ID;
            `TWD_SEL_REVISION:   read_mux = REVISION;
            `TWD_SEL_FLASH_CTL:  read_mux = c;
            `TWD_SEL_FLASH_DATA: read_mux = f;
            default:             read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // Link clock is the reset pin input, data rides the port pin
    twd_link u_link (
        .link_clk  (debug_link_clock),
        .srst      (srst),
        .link_din  (shared_port_pin_in),
        .link_dout (link_dout),
        .link_doe  (link_doe),
        .req_tgl   (req_tgl),
        .req_ins   (req_ins),
        .req_data  (req_data),
        .ack_tgl   (ack_tgl),
        .ack_data  (ack_data)
    );

    always_ff @(posedge clk)
    begin
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        pin_s1 <= shared_port_pin_in;
        pin_s2 <= pin_s1;
    end

    // Link words are stable once their toggle has passed two flops
    assign req_new = req_s2 != req_prev;
    assign data_wr = req_new && (req_ins == twd_pkg::TWD_INS_WR_DATA);
    assign core_stall = ctl[`TWD_CTL_HALT_BIT];

    // Debug owns the pin only while halted; user logic is cut off then
    always_comb
    begin
        if (core_stall)
        begin
            shared_port_pin_out = link_dout;
            shared_port_pin_oe  = link_doe;
        end
        else
        begin
            shared_port_pin_out = user_pin_out;
            shared_port_pin_oe  = user_pin_oe;
        end
    end

    always_comb
    begin
        next_ack_tgl   = ack_tgl;
        next_ack_data  = ack_data;
        next_sel       = sel;
        next_ctl       = ctl;
        next_fdata     = flash_prog_data_reg;
        next_cmd_phase = cmd_phase;
        next_flash_byte = flash_byte;
        next_strobe    = 1'b0;
        next_blk_rd    = 1'b0;
        next_blk_wr    = 1'b0;
        if (flash_rd_valid)
            next_fdata = flash_rd_byte;
        if (req_new)
        begin
            next_ack_tgl = ~ack_tgl;
            case (req_ins)
                twd_pkg::TWD_INS_WR_SEL:
                    next_sel = req_data;
                twd_pkg::TWD_INS_RD_SEL:
                    next_ack_data = sel;
                twd_pkg::TWD_INS_RD_DATA:
                    next_ack_data = read_mux(sel, ctl, flash_prog_data_reg);
                default:
                begin
                    if (sel == `TWD_SEL_FLASH_CTL)
                    begin
                        next_ctl       = req_data;
                        next_cmd_phase = req_data[`TWD_CTL_FLASH_BIT];
                    end
                    else if (sel == `TWD_SEL_FLASH_DATA && ctl[`TWD_CTL_FLASH_BIT])
                    begin
                        // First byte after enabling or after flash_cmd_done is a command, the others address/data
                        next_fdata      = req_data;
                        next_flash_byte = req_data;
                        next_strobe     = 1'b1;
                        next_cmd_phase  = 1'b0;
                        next_blk_rd = cmd_phase && (req_data == `TWD_CMD_BLOCK_READ);
                        next_blk_wr = cmd_phase && (req_data == `TWD_CMD_BLOCK_WRITE);
                    end
                end
            endcase
        end
        // Engine re-arm wins over a flash byte landing in the same cycle
        if (flash_cmd_done)
            next_cmd_phase = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            req_prev            <= 1'b0;
            ack_tgl             <= 1'b0;
            ack_data            <= 8'h00;
            sel                 <= `TWD_SEL_RESET;
            ctl                 <= `TWD_CTL_RESET;
            flash_prog_data_reg <= `TWD_FDATA_RESET;
            cmd_phase           <= 1'b0;
            flash_byte          <= 8'h00;
            flash_byte_strobe   <= 1'b0;
            flash_blk_rd_cmd    <= 1'b0;
            flash_blk_wr_cmd    <= 1'b0;
            user_pin_in         <= 1'b0;
        end
        else
        begin
            req_prev            <= req_s2;
            ack_tgl             <= next_ack_tgl;
            ack_data            <= next_ack_data;
            sel                 <= next_sel;
            ctl                 <= next_ctl;
            flash_prog_data_reg <= next_fdata;
            cmd_phase           <= next_cmd_phase;
            flash_byte          <= next_flash_byte;
            flash_byte_strobe   <= next_strobe;
            flash_blk_rd_cmd    <= next_blk_rd;
            flash_blk_wr_cmd    <= next_blk_wr;
            // User logic sees a frozen pin while the debug link borrows it
            if (!core_stall)
                user_pin_in <= pin_s2;
        end
    end

    a_ack_follows_req: assert property (
        @(posedge clk) disable iff (srst)
        req_new |=> (ack_tgl != $past(ack_tgl)))
        else $error("Link request not acknowledged next cycle");

    a_pin_owner: assert property (
        @(posedge clk) disable iff (srst)
        core_stall |-> (shared_port_pin_oe == link_doe))
        else $error("Shared pin not handed to link while halted");

    a_user_frozen: assert property (
        @(posedge clk) disable iff (srst)
        (core_stall && $past(core_stall)) |-> $stable(user_pin_in))
        else $error("User pin input moved while halted");

    a_blk_cmd_code: assert property (
        @(posedge clk) disable iff (srst)
        (data_wr && sel == `TWD_SEL_FLASH_DATA && ctl[`TWD_CTL_FLASH_BIT] && cmd_phase
         && req_data == `TWD_CMD_BLOCK_WRITE) |=> (flash_blk_wr_cmd && flash_byte_strobe))
        else $error("Block write command not decoded");

endmodule : twd_port

// ---- verif/twd_host.sv ----
// Behavioural debug host: makes the link clock and drives or releases the data wire
`timescale 1ns/1ps

module twd_host (
    output logic      link_clk,
    output logic      host_out,
    output logic      host_oe,
    input  wire logic pin
);
    initial
    begin
        link_clk = 1'b0;
        host_out = 1'b0;
        host_oe  = 1'b1;
    end

    // One link cycle; the host changes its drive just after the rising edge
    task automatic cyc(input logic nb, input logic noe);
        link_clk = 1'b1;
        #2;
        host_out = nb;
        host_oe  = noe;
        #14;
        link_clk = 1'b0;
        #16;
    endtask : cyc

    // Idle clocks with data low, only for the reset sequence
    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b1);
    endtask : idle

    // Clock stands still between frames; clock line is driven only by cyc, called from here and from idle
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                         output logic [7:0] rd, output logic ok);
        logic [10:0] q;
        int          n;
        int          k;
        q        = {wd, ins, 1'b1};
        n        = ins[0] ? 3 : 11;
        rd       = 8'h00;
        host_oe  = 1'b1;
        host_out = 1'b1;
        #16;
        for (int i = 1; i < n; i++)
            cyc(q[i], 1'b1);
        cyc(1'b0, 1'b0);
        // Slow answers tolerated up to the bound, then the frame counts as unanswered
        for (k = 0; k < 40 && pin !== 1'b1; k++)
            cyc(1'b0, 1'b0);
        ok = (k < 40);
        if (ins[0])
            for (int i = 0; i < 8; i++)
            begin
                cyc(1'b0, 1'b0);
                rd[i] = pin;
            end
        cyc(1'b0, 1'b1);
    endtask : frame
endmodule : twd_host

// ---- verif/twd_port_tb_top.sv ----
// Self-checking bench of the two-wire debug port against a behavioural host
`timescale 1ns/1ps

module twd_port_tb_top;
    localparam logic [7:0] PART = 8'hC3; // Arbitrary value
    localparam logic [7:0] REV  = 8'h2E; // Arbitrary value

    logic        clk;
    logic        srst;
    logic        link_clk;
    logic        host_out;
    logic        host_oe;
    wire logic   pin;
    logic        dut_out;
    logic        dut_oe;
    logic        user_pin_out;
    logic        user_pin_oe;
    logic        user_pin_in;
    logic        core_stall;
    logic [7:0]  flash_byte;
    logic        flash_byte_strobe;
    logic        rd_cmd;
    logic        wr_cmd;
    logic        flash_rd_valid;
    logic [7:0]  flash_rd_byte;
    logic        flash_cmd_done;
    int          fail_count;
    int          cmp_count;
    int          n_stb;
    int          n_rd;
    int          n_wr;
    logic [7:0]  last_byte;
    logic [7:0]  d;
    logic        ok_bit;
    logic [15:0] rows [5];

    // Undriven pin sits at a fixed low level behind the isolation resistor, whatever the user level
    assign pin = dut_oe ? dut_out : (host_oe ? host_out : 1'b0);

    twd_port #(.PART_ID(PART), .REVISION(REV)) DUT (
        .clk                 (clk),
        .srst                (srst),
        .debug_link_clock    (link_clk),
        .shared_port_pin_in  (pin),
        .shared_port_pin_out (dut_out),
        .shared_port_pin_oe  (dut_oe),
        .user_pin_out        (user_pin_out),
        .user_pin_oe         (user_pin_oe),
        .user_pin_in         (user_pin_in),
        .core_stall          (core_stall),
        .flash_byte          (flash_byte),
        .flash_byte_strobe   (flash_byte_strobe),
        .flash_blk_rd_cmd    (rd_cmd),
        .flash_blk_wr_cmd    (wr_cmd),
        .flash_rd_valid      (flash_rd_valid),
        .flash_rd_byte       (flash_rd_byte),
        .flash_cmd_done      (flash_cmd_done)
    );

    twd_host u_host (
        .link_clk (link_clk),
        .host_out (host_out),
        .host_oe  (host_oe),
        .pin      (pin)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        if (flash_byte_strobe === 1'b1)
        begin
            n_stb++;
            last_byte = flash_byte;
        end
        if (rd_cmd === 1'b1)
            n_rd++;
        if (wr_cmd === 1'b1)
            n_wr++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] sel, input logic [7:0] v, input logic need);
        logic [7:0] x;
        logic       ok;
        u_host.frame(2'h0, sel, x, ok);
        u_host.frame(2'h2, v, x, ok);
        if (need)
            chk({7'h00, ok}, 8'h01, "write answer");
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] sel, output logic [7:0] v);
        logic [7:0] x;
        logic       ok;
        u_host.frame(2'h0, sel, x, ok);
        u_host.frame(2'h3, 8'h00, v, ok);
        chk({7'h00, ok}, 8'h01, "read answer");
    endtask : reg_rd

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic stop_test();
        $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        #200000;
        fail_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        stop_test();
    end

    initial
    begin
        srst           <= 1'b1;
        user_pin_out   <= 1'b1;
        user_pin_oe    <= 1'b0;
        flash_rd_valid <= 1'b0;
        flash_rd_byte  <= 8'h00;
        flash_cmd_done <= 1'b0;
        fail_count = 0;
        cmp_count  = 0;
        n_stb      = 0;
        n_rd       = 0;
        n_wr       = 0;
        rows       = '{{8'h00, PART}, {8'h01, REV}, {8'h02, 8'h03}, {8'hB4, 8'h00},
                       {8'h55, 8'h00}};
        @(posedge clk);
        u_host.idle(4);
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        u_host.idle(4);
        settle();
        chk({7'h00, core_stall}, 8'h00, "stall after reset");
        chk({6'h00, dut_oe, dut_out}, 8'h01, "pin follows user");
        @(posedge clk);
        user_pin_out <= 1'b0;
        user_pin_oe  <= 1'b1;
        settle();
        chk({6'h00, dut_oe, dut_out}, 8'h02, "pin follows user oe");
        user_pin_oe  <= 1'b0;
        // Link frames before halt get no visible answer on the pin
        reg_wr(8'h02, 8'h03, 1'b0);
        settle();
        chk({7'h00, core_stall}, 8'h01, "halt stalls core");
        user_pin_out <= 1'b1;
        user_pin_oe  <= 1'b1;
        settle();
        chk({7'h00, dut_oe}, 8'h00, "link owns pin halted");
        reg_wr(8'h00, 8'hFF, 1'b1);
        reg_wr(8'h55, 8'h77, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            reg_rd(rows[i][15:8], d);
            chk(d, rows[i][7:0], "register read");
        end
        u_host.frame(2'h1, 8'h00, d, ok_bit);
        chk(d, 8'h55, "select read back");
        chk({7'h00, ok_bit}, 8'h01, "select read answer");
        chk(n_stb[7:0], 8'h00, "no flash byte yet");
        reg_wr(8'hB4, 8'h06, 1'b1);
        chk(last_byte, 8'h06, "block read byte");
        chk({n_rd[3:0], n_stb[3:0]}, 8'h11, "block read command");
        reg_wr(8'hB4, 8'hA5, 1'b1);
        chk(last_byte, 8'hA5, "flash data byte");
        chk({n_rd[3:0], n_stb[3:0]}, 8'h12, "data is no command");
        @(posedge clk);
        flash_cmd_done <= 1'b1;
        @(posedge clk);
        flash_cmd_done <= 1'b0;
        reg_wr(8'hB4, 8'h07, 1'b1);
        chk({n_wr[3:0], n_stb[3:0]}, 8'h13, "block write command");
        @(posedge clk);
        flash_rd_valid <= 1'b1;
        flash_rd_byte  <= 8'h3C;
        @(posedge clk);
        flash_rd_valid <= 1'b0;
        reg_rd(8'hB4, d);
        chk(d, 8'h3C, "flash read byte");
        reg_wr(8'h02, 8'h01, 1'b1);
        reg_wr(8'hB4, 8'h99, 1'b1);
        chk(n_stb[7:0], 8'h03, "flash off ignores byte");
        reg_wr(8'h02, 8'h00, 1'b0);
        settle();
        chk({5'h00, user_pin_in, core_stall, dut_oe}, 8'h05, "run returns pin");
        stop_test();
    end
endmodule : twd_port_tb_top
